// ===== design/mrr_motion_regs.sv
`timescale 1ns/1ps
`include "mrr_defs.svh"

module mrr_motion_regs #(
  parameter int ACC_W = 16
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic sclk_in,
  input wire logic ncs_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_out,
  input wire mrr_pkg::mrr_frame_t frame_in,
  input wire logic illum_req_in,
  output logic led_ctrl_out,
  output logic self_test_start_out
);
  import mrr_pkg::*;

  localparam logic signed [ACC_W-1:0] ACC_MAX = {1'b0, {(ACC_W-1){1'b1}}};
  localparam logic signed [ACC_W-1:0] ACC_MIN = {1'b1, {(ACC_W-1){1'b0}}};
  localparam logic signed [ACC_W-1:0] DISP_POS_W = ACC_W'(`MRR_DISP_POS);
  localparam logic signed [ACC_W-1:0] DISP_NEG_W = ACC_W'(`MRR_DISP_NEG);
  localparam int NSYNC = `MRR_SYNC_STAGES;

  // Link domain: bit counter and shifter, cleared while the port is deselected
  logic [4:0] bit_cnt_q;
  logic [7:0] shift_q;
  mrr_cmd_t cmd_q;
  logic rd_tog_q;
  logic wr_tog_q;
  wire spi_clr = ncs_n_in | ~reset_n_in;
  wire [7:0] byte_in = {shift_q[6:0], mosi_in};
  wire at_addr_last = (bit_cnt_q == `MRR_CNT_ADDR_LAST);
  wire at_data_last = (bit_cnt_q == `MRR_CNT_DATA_LAST);

  always_ff @(posedge sclk_in or posedge spi_clr) begin
    if (spi_clr) begin
      bit_cnt_q <= `MRR_CNT_ZERO;
      shift_q <= `MRR_BYTE_ZERO;
    end else begin
      if (bit_cnt_q != `MRR_CNT_DONE) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
      shift_q <= byte_in;
    end
  end

  // Command words are held here until the next serial command overwrites them
  always_ff @(posedge sclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmd_q <= '0;
      rd_tog_q <= 1'b0;
      wr_tog_q <= 1'b0;
    end else begin
      if (at_addr_last) begin
        cmd_q.is_write <= byte_in[7];
        cmd_q.addr <= byte_in[6:0];
        if (!byte_in[7]) begin
          rd_tog_q <= ~rd_tog_q;
        end
      end
      if (at_data_last && cmd_q.is_write) begin
        cmd_q.data <= byte_in;
        wr_tog_q <= ~wr_tog_q;
      end
    end
  end

  // Core domain: toggle synchronisers for read and write events
  logic [NSYNC-1:0] rd_sync_q;
  logic [NSYNC-1:0] wr_sync_q;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_sync_q <= '0;
      wr_sync_q <= '0;
    end else begin
      rd_sync_q <= {rd_sync_q[NSYNC-2:0], rd_tog_q};
      wr_sync_q <= {wr_sync_q[NSYNC-2:0], wr_tog_q};
    end
  end

  wire rd_ev = rd_sync_q[NSYNC-1] ^ rd_sync_q[NSYNC-2];
  wire wr_ev = wr_sync_q[NSYNC-1] ^ wr_sync_q[NSYNC-2];

  // Register decode
  wire rd_status = rd_ev && (cmd_q.addr == `MRR_ADDR_MOTION);
  wire rd_x = rd_ev && (cmd_q.addr == `MRR_ADDR_DX);
  wire rd_y = rd_ev && (cmd_q.addr == `MRR_ADDR_DY);
  wire wr_flush = wr_ev && (cmd_q.addr == `MRR_ADDR_FLUSH);
  wire wr_setup = wr_ev && (cmd_q.addr == `MRR_ADDR_SETUP);

  // Core state
  logic signed [ACC_W-1:0] acc_x_q;
  logic signed [ACC_W-1:0] acc_x_d;
  logic signed [ACC_W-1:0] acc_y_q;
  logic signed [ACC_W-1:0] acc_y_d;
  logic [7:0] snap_x_q;
  logic [7:0] snap_x_d;
  logic [7:0] snap_y_q;
  logic [7:0] snap_y_d;
  logic snap_valid_q;
  logic snap_valid_d;
  logic ovf_q;
  logic ovf_d;
  logic [7:0] setup_q;
  logic [7:0] setup_d;
  logic [7:0] squal_q;
  logic [7:0] pixsum_q;
  logic [7:0] peak_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic led_q;
  logic test_q;

  // Saturate an accumulator to the eight-bit report range
  function automatic logic [7:0] sat8(input logic signed [ACC_W-1:0] v);
    logic [7:0] r;
    r = v[7:0];
    if (v > DISP_POS_W) begin
      r = `MRR_DISP_POS;
    end else if (v < DISP_NEG_W) begin
      r = `MRR_DISP_NEG;
    end
    return r;
  endfunction : sat8

  wire res_hi = setup_q[`MRR_SETUP_RES_BIT];
  wire shutter_on = setup_q[`MRR_SETUP_SHUT_BIT];

  // Resolution scaling of per-frame motion
  wire signed [7:0] dx_scaled = res_hi ? frame_in.dx : (frame_in.dx >>> `MRR_LOW_RES_SHIFT);
  wire signed [7:0] dy_scaled = res_hi ? frame_in.dy : (frame_in.dy >>> `MRR_LOW_RES_SHIFT);

  // Snapshot taken on a status read, remainder kept in the accumulator
  wire [7:0] take_x = sat8(acc_x_q);
  wire [7:0] take_y = sat8(acc_y_q);
  wire signed [ACC_W-1:0] take_x_w = ACC_W'($signed(take_x));
  wire signed [ACC_W-1:0] take_y_w = ACC_W'($signed(take_y));
  wire signed [ACC_W-1:0] base_x = rd_status ? acc_x_q - take_x_w : acc_x_q;
  wire signed [ACC_W-1:0] base_y = rd_status ? acc_y_q - take_y_w : acc_y_q;

  // Frame accumulation with overflow detection
  wire frame_add = frame_in.valid;
  wire [ACC_W:0] sum_x = {base_x[ACC_W-1], base_x} + (ACC_W+1)'(dx_scaled);
  wire [ACC_W:0] sum_y = {base_y[ACC_W-1], base_y} + (ACC_W+1)'(dy_scaled);
  wire ov_x = frame_add && (sum_x[ACC_W] != sum_x[ACC_W-1]);
  wire ov_y = frame_add && (sum_y[ACC_W] != sum_y[ACC_W-1]);
  wire signed [ACC_W-1:0] clip_x = sum_x[ACC_W] ? ACC_MIN : ACC_MAX;
  wire signed [ACC_W-1:0] clip_y = sum_y[ACC_W] ? ACC_MIN : ACC_MAX;
  wire signed [ACC_W-1:0] new_x = ov_x ? clip_x : sum_x[ACC_W-1:0];
  wire signed [ACC_W-1:0] new_y = ov_y ? clip_y : sum_y[ACC_W-1:0];

  wire full_x = (acc_x_q == ACC_MAX) || (acc_x_q == ACC_MIN);
  wire full_y = (acc_y_q == ACC_MAX) || (acc_y_q == ACC_MIN);
  wire motion_pending = (acc_x_q != '0) || (acc_y_q != '0);
  wire ovf_clear = wr_flush || ((rd_x || rd_y) && snap_valid_q && !full_x && !full_y);

  wire [7:0] status_byte = {motion_pending, 2'b00, ovf_q, 3'b000, res_hi};

  always_comb begin
    acc_x_d = frame_add ? new_x : base_x;
    acc_y_d = frame_add ? new_y : base_y;
    if (wr_flush) begin
      acc_x_d = '0;
      acc_y_d = '0;
    end
  end

  always_comb begin
    snap_x_d = snap_x_q;
    snap_y_d = snap_y_q;
    snap_valid_d = snap_valid_q;
    if (wr_flush) begin
      snap_x_d = `MRR_BYTE_ZERO;
      snap_y_d = `MRR_BYTE_ZERO;
      snap_valid_d = 1'b0;
    end else if (rd_status) begin
      snap_x_d = take_x;
      snap_y_d = take_y;
      snap_valid_d = 1'b1;
    end else begin
      if (rd_x) begin
        snap_x_d = `MRR_BYTE_ZERO;
      end
      if (rd_y) begin
        snap_y_d = `MRR_BYTE_ZERO;
        snap_valid_d = 1'b0;
      end
    end
  end

  // Overflow is sticky; a new overflow wins over a clear
  always_comb begin
    ovf_d = ovf_q;
    if (ov_x || ov_y) begin
      ovf_d = 1'b1;
    end else if (ovf_clear) begin
      ovf_d = 1'b0;
    end
  end

  // Setup register: bit 7 stays zero, reserved bits keep their reset value
  always_comb begin
    setup_d = setup_q;
    if (wr_setup) begin
      setup_d = (cmd_q.data & `MRR_SETUP_WR_MASK) | (setup_q & `MRR_SETUP_RSVD_MASK);
    end
  end

  // Read data mux, unmapped addresses read zero
  always_comb begin
    rdata_d = rdata_q;
    if (rd_ev) begin
      unique case (cmd_q.addr)
        `MRR_ADDR_MOTION: rdata_d = status_byte;
        `MRR_ADDR_DX: rdata_d = snap_x_q;
        `MRR_ADDR_DY: rdata_d = snap_y_q;
        `MRR_ADDR_SQUAL: rdata_d = squal_q;
        `MRR_ADDR_PIXSUM: rdata_d = pixsum_q;
        `MRR_ADDR_PEAK: rdata_d = peak_q;
        `MRR_ADDR_SETUP: rdata_d = setup_q;
        default: rdata_d = `MRR_BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_x_q <= '0;
      acc_y_q <= '0;
      snap_x_q <= `MRR_BYTE_ZERO;
      snap_y_q <= `MRR_BYTE_ZERO;
      snap_valid_q <= 1'b0;
      ovf_q <= 1'b0;
      setup_q <= `MRR_SETUP_RST;
      rdata_q <= `MRR_BYTE_ZERO;
    end else begin
      acc_x_q <= acc_x_d;
      acc_y_q <= acc_y_d;
      snap_x_q <= snap_x_d;
      snap_y_q <= snap_y_d;
      snap_valid_q <= snap_valid_d;
      ovf_q <= ovf_d;
      setup_q <= setup_d;
      rdata_q <= rdata_d;
    end
  end

  // Frame statistics, zero until the first frame arrives
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      squal_q <= `MRR_BYTE_ZERO;
      pixsum_q <= `MRR_BYTE_ZERO;
      peak_q <= `MRR_BYTE_ZERO;
    end else if (frame_in.valid) begin
      squal_q <= frame_in.feature_count[`MRR_SQUAL_LSB +: 8];
      pixsum_q <= frame_in.pixel_sum[`MRR_PIXSUM_LSB +: 8];
      peak_q <= {2'b00, frame_in.peak};
    end
  end

  // Lamp control and self-check start pulse
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      led_q <= 1'b1;
      test_q <= 1'b0;
    end else begin
      led_q <= shutter_on ? illum_req_in : 1'b1;
      test_q <= wr_setup && cmd_q.data[`MRR_SETUP_TEST_BIT];
    end
  end

  assign led_ctrl_out = led_q;
  assign self_test_start_out = test_q;

  // Read data shifted out MSB first; the byte is stable once the host waits
  wire data_phase = (bit_cnt_q >= `MRR_CNT_DATA_FIRST) && (bit_cnt_q != `MRR_CNT_DONE);
  assign miso_oe_out = !ncs_n_in && data_phase && !cmd_q.is_write;
  assign miso_out = miso_oe_out ? rdata_q[~bit_cnt_q[2:0]] : 1'b0;

endmodule : mrr_motion_regs

// ===== include/mrr_defs.svh
`ifndef MRR_DEFS_SVH
`define MRR_DEFS_SVH

`define MRR_ADDR_MOTION 7'h02
`define MRR_ADDR_DX 7'h03
`define MRR_ADDR_DY 7'h04
`define MRR_ADDR_SQUAL 7'h05
`define MRR_ADDR_PIXSUM 7'h06
`define MRR_ADDR_PEAK 7'h07
`define MRR_ADDR_SETUP 7'h0A
`define MRR_ADDR_FLUSH 7'h12

`define MRR_MOT_BIT 7
`define MRR_OVF_BIT 4
`define MRR_RES_BIT 0
`define MRR_SETUP_SHUT_BIT 6
`define MRR_SETUP_TEST_BIT 5
`define MRR_SETUP_RES_BIT 4
`define MRR_SETUP_RST 8'h09
`define MRR_SETUP_RSVD_MASK 8'h0F
`define MRR_SETUP_WR_MASK 8'h70

`define MRR_SQUAL_LSB 2
`define MRR_PIXSUM_LSB 8
`define MRR_LOW_RES_SHIFT 2
`define MRR_DISP_POS 8'sh7F
`define MRR_DISP_NEG 8'sh80
`define MRR_BYTE_ZERO 8'h00

`define MRR_CNT_ZERO 5'h00
`define MRR_CNT_ADDR_LAST 5'h07
`define MRR_CNT_DATA_FIRST 5'h08
`define MRR_CNT_DATA_LAST 5'h0F
`define MRR_CNT_DONE 5'h10
`define MRR_SYNC_STAGES 3

`endif

// ===== include/mrr_pkg.sv
package mrr_pkg;

  // One processed frame from the navigation engine
  typedef struct packed {
    logic valid;
    logic signed [7:0] dx;
    logic signed [7:0] dy;
    logic [9:0] feature_count;
    logic [15:0] pixel_sum;
    logic [5:0] peak;
  } mrr_frame_t;

  // Serial command held in the link domain
  typedef struct packed {
    logic is_write;
    logic [6:0] addr;
    logic [7:0] data;
  } mrr_cmd_t;

endpackage : mrr_pkg

// ===== dv/mrr_motion_regs_props.sv
`timescale 1ns/1ps
module mrr_motion_regs_props #(
  parameter int ACC_W = 16
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic sclk_in,
  input wire logic ncs_n_in,
  input wire logic mosi_in,
  input wire logic miso_out,
  input wire logic miso_oe_out,
  input wire mrr_pkg::mrr_frame_t frame_in,
  input wire logic illum_req_in,
  input wire logic led_ctrl_out,
  input wire logic self_test_start_out
);
  import mrr_pkg::*;
  // Serial edges seen since select went low
  logic [4:0] bit_cnt_q;
  logic [4:0] bit_cnt_d;
  assign bit_cnt_d = (bit_cnt_q == 5'h1F) ? bit_cnt_q : bit_cnt_q + 5'h01;
  always_ff @(posedge sclk_in or posedge ncs_n_in) begin
    if (ncs_n_in) begin
      bit_cnt_q <= 5'h00;
    end else begin
      bit_cnt_q <= bit_cnt_d;
    end
  end
  property p_oe_ncs;
    @(posedge core_clk_in) disable iff (!reset_n_in) ncs_n_in |-> !miso_oe_out;
  endproperty
  a_oe_ncs: assert property (p_oe_ncs) else $error("miso driven while deselected");
  property p_oe_window;
    @(posedge sclk_in) disable iff (!reset_n_in || ncs_n_in)
      miso_oe_out |-> (bit_cnt_q >= 5'h08) && (bit_cnt_q <= 5'h0F);
  endproperty
  a_oe_window: assert property (p_oe_window) else $error("miso driven outside data byte");
  property p_oe_hold;
    @(posedge sclk_in) disable iff (!reset_n_in || ncs_n_in) $rose(miso_oe_out) |-> miso_oe_out [*8];
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("read byte cut short");
  property p_miso_off;
    @(posedge core_clk_in) disable iff (!reset_n_in) !miso_oe_out |-> !miso_out;
  endproperty
  a_miso_off: assert property (p_miso_off) else $error("miso not low when idle");
  property p_miso_hold;
    @(posedge core_clk_in) disable iff (!reset_n_in || ncs_n_in)
      miso_oe_out && !sclk_in && !$past(sclk_in) |-> $stable(miso_out);
  endproperty
  a_miso_hold: assert property (p_miso_hold) else $error("miso changed while serial clock low");
  property p_led_req;
    @(posedge core_clk_in) disable iff (!reset_n_in) illum_req_in |=> led_ctrl_out;
  endproperty
  a_led_req: assert property (p_led_req) else $error("lamp off while requested");
  property p_led_off;
    @(posedge core_clk_in) disable iff (!reset_n_in) !led_ctrl_out |-> !$past(illum_req_in);
  endproperty
  a_led_off: assert property (p_led_off) else $error("lamp off without cause");
  property p_rst_out;
    @(posedge core_clk_in) disable iff (!reset_n_in) $rose(reset_n_in) |-> led_ctrl_out && !self_test_start_out;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs wrong after reset");
  property p_st_pulse;
    @(posedge core_clk_in) disable iff (!reset_n_in) self_test_start_out |=> !self_test_start_out;
  endproperty
  a_st_pulse: assert property (p_st_pulse) else $error("self check pulse too long");
  c_st: cover property (@(posedge core_clk_in) self_test_start_out);
  c_led: cover property (@(posedge core_clk_in) !led_ctrl_out);
  c_oe: cover property (@(posedge sclk_in) $rose(miso_oe_out));
endmodule : mrr_motion_regs_props
bind mrr_motion_regs mrr_motion_regs_props #(.ACC_W(ACC_W)) u_props (.core_clk_in, .reset_n_in, .sclk_in,
  .ncs_n_in, .mosi_in, .miso_out, .miso_oe_out, .frame_in, .illum_req_in, .led_ctrl_out, .self_test_start_out);

// ===== dv/mrr_host_model.sv
`timescale 1ns/1ps
module mrr_host_model (
  output logic sclk_out,
  output logic ncs_n_out,
  output logic mosi_out,
  input wire logic miso_in
);
  initial begin
    sclk_out = 1'b1;
    ncs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // Mode 3 frame; clock idles high, released mosi shows inverted last value
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {wr, a, d};
    rd = 8'h00;
    #7 ncs_n_out = 1'b0;
    for (int i = 0; i < 16; i++) begin
      #15 sclk_out = 1'b0;
      mosi_out = (wr || i < 8) ? sh[15 - i] : ~mosi_out;
      #15 if (!wr && i >= 8) rd = {rd[6:0], miso_in};
      sclk_out = 1'b1;
      if (i == 7) #60;
    end
    #15 ncs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    #60;
  endtask : xfer
endmodule : mrr_host_model

// ===== dv/tb_motion_report_registers.sv
`timescale 1ns/1ps
module tb_motion_report_registers;
  import mrr_pkg::*;
  int err_total = 0;
  int n_tests = 0;
  int st_cnt = 0;
  logic clk, rst_n, sclk, ncs_n, mosi, miso, miso_oe, illum, led, st;
  logic [7:0] rd_q;
  mrr_frame_t frame;
  mrr_motion_regs #(.ACC_W(10)) dut (.core_clk_in(clk), .reset_n_in(rst_n), .sclk_in(sclk), .ncs_n_in(ncs_n),
    .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe), .frame_in(frame), .illum_req_in(illum),
    .led_ctrl_out(led), .self_test_start_out(st));
  mrr_host_model u_host (.sclk_out(sclk), .ncs_n_out(ncs_n), .mosi_out(mosi), .miso_in(miso));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(negedge clk) if (st === 1'b1) st_cnt++;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rc(input logic [6:0] a, input logic [7:0] exp);
    u_host.xfer(1'b0, a, 8'h00, rd_q);
    chk(rd_q, exp);
  endtask : rc
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, d, rd_q);
  endtask : wr
  task automatic mcyc(input logic [7:0] s, input logic [7:0] x, input logic [7:0] y);
    rc(7'h02, s);
    rc(7'h03, x);
    rc(7'h04, y);
  endtask : mcyc
  task automatic fr(input logic [7:0] dx, input logic [7:0] dy, input logic [9:0] fc, input logic [15:0] ps,
    input logic [5:0] pk);
    @(negedge clk);
    frame = '{1'b1, dx, dy, fc, ps, pk};
    @(negedge clk);
    frame.valid = 1'b0;
    repeat (4) @(negedge clk);
  endtask : fr
  task automatic lamp(input logic req, input logic exp);
    @(negedge clk);
    illum = req;
    repeat (4) @(negedge clk);
    chk({7'h00, led}, {7'h00, exp});
  endtask : lamp
  task automatic t_reset();
    rc(7'h0A, 8'h09);
    rc(7'h02, 8'h00);
    for (int a = 3; a <= 8; a++) rc(7'(a), 8'h00);
  endtask : t_reset
  task automatic t_stats();
    fr(8'h00, 8'h00, 10'h2A6, 16'hDDFF, 6'h3F);
    rc(7'h05, 8'hA9);
    rc(7'h06, 8'hDD);
    wr(7'h07, 8'hFF);
    rc(7'h07, 8'h3F);
  endtask : t_stats
  task automatic t_setup();
    wr(7'h0A, 8'hFF);
    rc(7'h0A, 8'h79);
    rc(7'h02, 8'h01);
    chk(8'(st_cnt), 8'h01);
    lamp(1'b0, 1'b0);
    lamp(1'b1, 1'b1);
  endtask : t_setup
  task automatic t_motion();
    fr(8'h05, 8'hFD, '0, '0, '0);
    mcyc(8'h81, 8'h05, 8'hFD);
    rc(7'h03, 8'h00);
    rc(7'h04, 8'h00);
    fr(8'h0A, 8'h00, '0, '0, '0);
    rc(7'h02, 8'h81);
    fr(8'h07, 8'h00, '0, '0, '0);
    mcyc(8'h81, 8'h07, 8'h00);
  endtask : t_motion
  task automatic t_drain();
    logic [7:0] ex [3];
    ex = '{8'h7F, 8'h7F, 8'h2E};
    repeat (3) fr(8'h64, 8'h00, '0, '0, '0);
    for (int i = 0; i < 3; i++) mcyc(8'h81, ex[i], 8'h00);
    rc(7'h02, 8'h01);
  endtask : t_drain
  task automatic t_ovf();
    repeat (5) fr(8'h7F, 8'h00, '0, '0, '0);
    mcyc(8'h91, 8'h7F, 8'h00);
    rc(7'h02, 8'h81);
    wr(7'h12, 8'h5A);
    mcyc(8'h01, 8'h00, 8'h00);
  endtask : t_ovf
  task automatic t_low();
    wr(7'h0A, 8'h00);
    rc(7'h0A, 8'h09);
    lamp(1'b0, 1'b1);
    fr(8'h14, 8'hF8, '0, '0, '0);
    mcyc(8'h80, 8'h05, 8'hFE);
    chk(8'(st_cnt), 8'h01);
  endtask : t_low
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    rst_n = 1'b0;
    illum = 1'b0;
    frame = '0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_reset();
    t_stats();
    t_setup();
    t_motion();
    t_drain();
    t_ovf();
    t_low();
    report_and_stop();
  end
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
endmodule : tb_motion_report_registers
